/* File: pwmbt_pkg.sv */
// Shared constants for the PWM bank with tuning modulator.
package pwmbt_pkg;

	// Clock and step timing.
	localparam int CLK_FREQ_MHZ = 25;
	localparam int STEP_TIME_NS = 330;
	localparam int STEP_CYCLES_CALC = (STEP_TIME_NS * CLK_FREQ_MHZ) / 1000;
	localparam int STEP_CYCLES = (STEP_CYCLES_CALC < 1) ? 1 : STEP_CYCLES_CALC;

	// Channel and tuning field widths.
	localparam int CHAN_COUNT = 8;
	localparam int CHAN_VALUE_W = 6;
	localparam int TUNE_HALF_W = 7;
	localparam int TUNE_VALUE_W = 14;
	localparam int REG_W = 8;
	localparam int ENABLE_BIT = 7;

	// Register map, byte addresses.
	localparam int APB_ADDR_W = 12;
	localparam logic [11:0] ADDR_CHAN_BASE = 12'h000;
	localparam logic [11:0] ADDR_CHAN_LAST = 12'h01c;
	localparam logic [11:0] ADDR_TUNE_LOW = 12'h020;
	localparam logic [11:0] ADDR_TUNE_HIGH = 12'h024;
	localparam logic [11:0] ADDR_STATUS = 12'h028;
	localparam logic [11:0] ADDR_ACTIVE = 12'h02c;

	// Reset values.
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] TUNE_RESET = 8'h00;

	// Status register field positions.
	localparam int STAT_TUNE_OUT_BIT = 8;
	localparam int STAT_TUNE_EN_BIT = 9;
	localparam int STAT_PENDING_BIT = 10;

endpackage

/* File: pwmbt_tune_if.sv */
// Interface between the register side and the tuning modulator.
`timescale 1ns/1ns
interface pwmbt_tune_if;
	logic [6:0] phase;
	logic wrap;
	logic load;
	logic [13:0] value;
	logic enable;
	logic pwmOut;
	logic [13:0] activeValue;
	logic activeEnable;
	logic pending;

	modport ctrl (
		output phase, wrap, load, value, enable,
		input pwmOut, activeValue, activeEnable, pending
	);
	modport tuner (
		input phase, wrap, load, value, enable,
		output pwmOut, activeValue, activeEnable, pending
	);
endinterface

/* File: pwmbt_tuning.sv */
// Fourteen-bit tuning modulator with coarse high time and spread fine extension.
`timescale 1ns/1ns
module pwmbt_tuning
	import pwmbt_pkg::*;
(
	input wire logic sys_clk, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	pwmbt_tune_if.tuner tif // Control and status towards the register side.
);

	logic [13:0] pending_q;
	logic pendingEn_q;
	logic pendingValid_q;
	logic [13:0] active_q;
	logic activeEn_q;
	logic [6:0] periodCount_q;
	logic [6:0] periodRev;
	logic extend;
	logic [7:0] highSteps;
	logic out_q;

	// Bit reversal of the period count spreads the extended periods evenly.
	genvar b;
	generate
		for (b = 0; b < TUNE_HALF_W; b++) begin : g_rev
			assign periodRev[b] = periodCount_q[TUNE_HALF_W - 1 - b];
		end
	endgenerate

	// A high-register write arms the new value; it goes live at the next period start.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pending_q <= '0;
			pendingEn_q <= 1'b0;
			pendingValid_q <= 1'b0;
		end else if (tif.load) begin
			pending_q <= tif.value; // RULE_10
			pendingEn_q <= tif.enable;
			pendingValid_q <= ~tif.wrap;
		end else if (tif.wrap) begin
			pendingValid_q <= 1'b0;
		end
	end

	// Active value changes only at a period boundary, so no period is cut short.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			active_q <= '0;
			activeEn_q <= 1'b0;
		end else if (tif.wrap && tif.load) begin
			active_q <= tif.value; // RULE_10
			activeEn_q <= tif.enable;
		end else if (tif.wrap && pendingValid_q) begin
			active_q <= pending_q; // RULE_10
			activeEn_q <= pendingEn_q;
		end
	end

	// Counts periods within the 128-period cycle.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			periodCount_q <= '0;
		end else if (tif.wrap) begin
			periodCount_q <= periodCount_q + 7'h01; // RULE_09
		end
	end

	// High time is the coarse part plus one step in N of every 128 periods.
	assign extend = (periodRev < active_q[TUNE_HALF_W - 1:0]); // RULE_09 RULE_13
	assign highSteps = {1'b0, active_q[TUNE_VALUE_W - 1:TUNE_HALF_W]} + {7'h00, extend}; // RULE_08

	// Output is high while the phase is below the high time and the modulator is enabled.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			out_q <= 1'b0;
		end else begin
			out_q <= activeEn_q && ({1'b0, tif.phase} < highSteps); // RULE_06 RULE_07 RULE_13
		end
	end

	assign tif.pwmOut = out_q;
	assign tif.activeValue = active_q;
	assign tif.activeEnable = activeEn_q;
	assign tif.pending = pendingValid_q;

endmodule

/* File: pwmbt_bank.sv */
// APB register file, step timing and eight 6-bit modulators of the PWM bank.
`timescale 1ns/1ns

// Summary of operation
// RULE_01: Eight independent channels with 6-bit high time.
// RULE_02: Channel period fixed at 64 steps.
// RULE_03: High time equals value times one step.
// RULE_04: Channel pulses only while its enable set.
// RULE_05: High time from control bits five to zero.
// RULE_06: Extra 14-bit tuning modulator, 128-step period.
// RULE_07: Tuning has low/high registers, enable in high.
// RULE_08: Upper seven bits give coarse high steps.
// RULE_09: Lower seven bits extend N of 128.
// RULE_10: Only high-register write loads new value.
// RULE_11: Software writes low register before high register.
// RULE_12: Common one-step tick drives all modulators.
// RULE_13: Extensions spread evenly; disabled output stays low.
module pwmbt_bank
	import pwmbt_pkg::*;
#(
	parameter int STEP_LEN = STEP_CYCLES
)(
	input wire logic sys_clk, // System clock, 25 MHz.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable, access phase.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [APB_ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic [3:0] pstrb, // APB write byte strobes.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped address.
	output logic [CHAN_COUNT-1:0] pwmOut, // Channel modulator outputs.
	output logic tuningOut // Tuning modulator output.
);

	pwmbt_tune_if tif ();

	// Prescaler width follows the step length, so a longer step never overflows the counter.
	localparam int STEP_W = (STEP_LEN > 1) ? $clog2(STEP_LEN) : 1;

	logic [STEP_W-1:0] stepCount_q;
	logic tick;
	logic [6:0] phase_q;
	logic chanWrap;
	logic tuneWrap;

	logic setupPhase;
	logic accessPhase;
	logic wrEn;
	logic alignedOk;
	logic selChan;
	logic selLow;
	logic selHigh;
	logic selStatus;
	logic selActive;
	logic mapped;
	logic [2:0] chanIndex;
	logic [CHAN_COUNT-1:0] chanSel;

	logic [REG_W-1:0] chanCtrl_q [CHAN_COUNT];
	logic [REG_W-1:0] chanLive_q [CHAN_COUNT];
	logic [CHAN_COUNT-1:0] pwmOut_q;
	logic [REG_W-1:0] tuneLow_q;
	logic [REG_W-1:0] tuneHigh_q;
	logic tuningOut_q;

	logic [31:0] prdata_d;
	logic [31:0] prdata_q;
	logic pslverr_d;
	logic pslverr_q;
	logic pready_q;
	logic [31:0] statusWord;

	// Step prescaler: one tick every STEP_LEN system clocks, about one third microsecond.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stepCount_q <= '0;
		end else if (tick) begin
			stepCount_q <= '0; // RULE_12
		end else begin
			stepCount_q <= stepCount_q + STEP_W'(1);
		end
	end

	assign tick = (stepCount_q == STEP_W'(STEP_LEN - 1)); // RULE_12

	// Shared phase counter; its low six bits run the channels, all seven the tuner.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			phase_q <= '0;
		end else if (tick) begin
			phase_q <= phase_q + 7'h01; // RULE_12
		end
	end

	// Period boundaries: 64 steps for channels, 128 for the tuner.
	assign chanWrap = tick && (phase_q[CHAN_VALUE_W-1:0] == 6'h3f); // RULE_02
	assign tuneWrap = tick && (phase_q == 7'h7f); // RULE_06

	// APB phase decode; pready is high in every access phase, so no wait states.
	assign setupPhase = psel && !penable;
	assign accessPhase = psel && penable && pready_q;
	assign wrEn = accessPhase && pwrite && pstrb[0];

	// Address decode of word-aligned registers.
	assign alignedOk = (paddr[1:0] == 2'b00);
	assign selChan = alignedOk && (paddr >= ADDR_CHAN_BASE) && (paddr <= ADDR_CHAN_LAST);
	assign selLow = (paddr == ADDR_TUNE_LOW);
	assign selHigh = (paddr == ADDR_TUNE_HIGH);
	assign selStatus = (paddr == ADDR_STATUS);
	assign selActive = (paddr == ADDR_ACTIVE);
	assign mapped = selChan || selLow || selHigh || selStatus || selActive;
	assign chanIndex = paddr[4:2];

	// Per-channel registers, period latch and output comparator.
	genvar c;
	generate
		for (c = 0; c < CHAN_COUNT; c++) begin : g_chan
			assign chanSel[c] = selChan && (chanIndex == 3'(c));

			// Control register: enable in bit seven, high time in bits five to zero.
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					chanCtrl_q[c] <= CTRL_RESET;
				end else if (wrEn && chanSel[c]) begin
					chanCtrl_q[c] <= pwdata[REG_W-1:0]; // RULE_05
				end
			end

			// Settings are taken at the period boundary, so a write never splits a pulse.
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					chanLive_q[c] <= CTRL_RESET;
				end else if (chanWrap) begin
					chanLive_q[c] <= chanCtrl_q[c]; // RULE_02
				end
			end

			// High while the phase is below the value; held low when disabled.
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					pwmOut_q[c] <= 1'b0;
				end else begin
					pwmOut_q[c] <= chanLive_q[c][ENABLE_BIT] && // RULE_04 RULE_13
						(phase_q[CHAN_VALUE_W-1:0] < chanLive_q[c][CHAN_VALUE_W-1:0]); // RULE_01 RULE_03
				end
			end
		end
	endgenerate

	// Tuning low register holds the fine half until the high register is written.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tuneLow_q <= TUNE_RESET;
		end else if (wrEn && selLow) begin
			tuneLow_q <= {1'b0, pwdata[TUNE_HALF_W-1:0]}; // RULE_07
		end
	end

	// Tuning high register: enable in bit seven, coarse half below it.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tuneHigh_q <= TUNE_RESET;
		end else if (wrEn && selHigh) begin
			tuneHigh_q <= pwdata[REG_W-1:0]; // RULE_07
		end
	end

	// Writing the high register hands the full value, built from both halves, to the tuner.
	assign tif.phase = phase_q;
	assign tif.wrap = tuneWrap;
	assign tif.load = wrEn && selHigh; // RULE_10 RULE_11
	assign tif.value = {pwdata[TUNE_HALF_W-1:0], tuneLow_q[TUNE_HALF_W-1:0]};
	assign tif.enable = pwdata[ENABLE_BIT];

	pwmbt_tuning u_tuning (
		.sys_clk(sys_clk),
		.reset(reset),
		.tif(tif)
	);

	// Tuner output is re-registered so the top output comes from a local flop.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tuningOut_q <= 1'b0;
		end else begin
			tuningOut_q <= tif.pwmOut;
		end
	end

	// Status word: live outputs, tuner enable and load-pending flag.
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[CHAN_COUNT-1:0] = pwmOut_q;
		statusWord[STAT_TUNE_OUT_BIT] = tuningOut_q;
		statusWord[STAT_TUNE_EN_BIT] = tif.activeEnable;
		statusWord[STAT_PENDING_BIT] = tif.pending;
	end

	// Read multiplexer; unmapped addresses read zero and flag an error.
	always_comb begin
		prdata_d = 32'h0000_0000;
		pslverr_d = 1'b0;
		if (!mapped) begin
			pslverr_d = 1'b1;
		end else if (selChan) begin
			prdata_d = {24'h000000, chanCtrl_q[chanIndex]};
		end else if (selLow) begin
			prdata_d = {24'h000000, tuneLow_q};
		end else if (selHigh) begin
			prdata_d = {24'h000000, tuneHigh_q};
		end else if (selStatus) begin
			prdata_d = statusWord;
		end else begin
			prdata_d = {18'h0, tif.activeValue};
		end
	end

	// Ready is raised for the one cycle after each setup cycle, so there are no wait states.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setupPhase;
		end
	end

	// Read data is captured in the setup cycle; writes and idle cycles show zero.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata_q <= 32'h0000_0000;
		end else if (setupPhase && !pwrite) begin
			prdata_q <= prdata_d;
		end else begin
			prdata_q <= 32'h0000_0000;
		end
	end

	// The error flag accompanies ready when no register answers at the address.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= setupPhase && pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pwmOut = pwmOut_q;
	assign tuningOut = tuningOut_q;

endmodule

/* File: pwmbt_bank_properties.sv */
// Port-level checks of the PWM bank, bound to the top module.
`timescale 1ns/1ns
module pwmbt_bank_properties
	import pwmbt_pkg::*;
#(
	parameter int STEP_LEN = STEP_CYCLES
)(
	input wire logic sys_clk, // Clock.
	input wire logic reset, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Enable.
	input wire logic pwrite, // Direction.
	input wire logic [APB_ADDR_W-1:0] paddr, // Address.
	input wire logic [31:0] pwdata, // Write data.
	input wire logic [3:0] pstrb, // Strobes.
	input wire logic [31:0] prdata, // Read data.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic [CHAN_COUNT-1:0] pwmOut, // Channel outputs.
	input wire logic tuningOut // Tuning output.
);
	int sinceCh;
	int sinceTu;
	logic chSeen;
	logic tuSeen;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// Counts cycles since the last channel rise, the period reference.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sinceCh <= 0;
			chSeen <= 1'b0;
		end else if ((pwmOut & ~$past(pwmOut)) != '0) begin
			sinceCh <= 1;
			chSeen <= 1'b1;
		end else begin
			sinceCh <= sinceCh + 1;
		end
	end

	// Counts cycles since the last tuning rise.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sinceTu <= 0;
			tuSeen <= 1'b0;
		end else if ($rose(tuningOut)) begin
			sinceTu <= 1;
			tuSeen <= 1'b1;
		end else begin
			sinceTu <= sinceTu + 1;
		end
	end

	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("pslverr without pready or with data");
	chk_bad_addr: assert property (psel && !penable && (paddr[1:0] != 2'h0 ||
		paddr > ADDR_ACTIVE) |=> pslverr)
		else $error("unmapped address not refused");
	chk_reset_quiet: assert property ($fell(reset) |-> pwmOut == '0 && !tuningOut)
		else $error("outputs active after reset");
	chk_chan_period: assert property (chSeen && (pwmOut & ~$past(pwmOut)) != '0
		|-> sinceCh % (64 * STEP_LEN) == 0)
		else $error("channel rise off the period grid");
	chk_chan_width: assert property (chSeen && (~pwmOut & $past(pwmOut)) != '0
		|-> sinceCh % STEP_LEN == 0)
		else $error("channel fall off the step grid");
	chk_tune_period: assert property (tuSeen && $rose(tuningOut)
		|-> sinceTu % (128 * STEP_LEN) == 0)
		else $error("tuning rise off the period grid");
	chk_tune_width: assert property (tuSeen && $fell(tuningOut) |-> sinceTu % STEP_LEN == 0)
		else $error("tuning fall off the step grid");
endmodule

bind pwmbt_bank pwmbt_bank_properties #(.STEP_LEN(STEP_LEN)) u_props (.sys_clk(sys_clk),
	.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pwmOut(pwmOut), .tuningOut(tuningOut));

/* File: pwmbt_lpf_model.sv */
// Model of the external low-pass network fed by one modulator output.
`timescale 1ns/1ns
module pwmbt_lpf_model (
	input wire logic sys_clk, // Clock that times the waveform.
	input wire logic reset, // Clears the measurements.
	input wire logic pwmIn, // Modulator output into the network.
	output logic [31:0] lastHigh, // Last complete high pulse in cycles.
	output logic [31:0] lastPeriod, // Spacing of the last two rises.
	output logic [31:0] totalHigh // Charge taken in, as high cycles.
);
	logic prevIn;
	logic [31:0] hiRun;
	logic [31:0] perRun;

	// Integrates the input and times each pulse and period.
	always_ff @(posedge sys_clk) begin
		prevIn <= pwmIn;
		if (reset) begin
			totalHigh <= 32'h0;
			hiRun <= 32'h0;
			perRun <= 32'h0;
			lastHigh <= 32'h0;
			lastPeriod <= 32'h0;
		end else begin
			totalHigh <= totalHigh + {31'h0, pwmIn};
			hiRun <= pwmIn ? hiRun + 32'h1 : 32'h0;
			perRun <= (pwmIn && !prevIn) ? 32'h1 : perRun + 32'h1;
			if (pwmIn && !prevIn)
				lastPeriod <= perRun;
			if (!pwmIn && prevIn)
				lastHigh <= hiRun;
		end
	end
endmodule

/* File: tb_pwmbt_bank.sv */
// Self-checking bench for the PWM bank with tuning modulator.
`timescale 1ns/1ns
module tb_pwmbt_bank
	import pwmbt_pkg::*;
;
	localparam int STEP = 2;
	localparam int CPER = 64 * STEP;
	localparam int TPER = 128 * STEP;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] pwmOut;
	logic tuningOut;
	logic [8:0] wave;
	logic [31:0] hiW [9];
	logic [31:0] perW [9];
	logic [31:0] totW [9];
	logic [31:0] t0;
	logic [31:0] r;
	logic e;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;

	assign wave = {tuningOut, pwmOut};

	pwmbt_bank #(.STEP_LEN(STEP)) DUT (.sys_clk(sys_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pwmOut(pwmOut),
		.tuningOut(tuningOut));

	// One network model on each modulator output.
	for (genvar i = 0; i < 9; i++) begin : g_net
		pwmbt_lpf_model u_net (.sys_clk(sys_clk), .reset(reset), .pwmIn(wave[i]),
			.lastHigh(hiW[i]), .lastPeriod(perW[i]), .totalHigh(totW[i]));
	end

	// Clock generation.
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic final_report();
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; holds the request until pready is seen high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
		check("write error", 32'h0, {31'h0, e});
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
		apb(1'b0, a, 32'h0, 4'hf);
		check("read data", exp, r);
		check("read error", {31'h0, experr}, {31'h0, e});
	endtask

	// Main sequence.
	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 8; i++) rd(ADDR_CHAN_BASE + 12'(4 * i), 32'h0, 1'b0);
		rd(ADDR_TUNE_HIGH, 32'h0, 1'b0);
		rd(ADDR_STATUS, 32'h0, 1'b0);
		rd(12'h030, 32'h0, 1'b1);
		rd(12'h002, 32'h0, 1'b1);
		for (int i = 0; i < 8; i++) wr(ADDR_CHAN_BASE + 12'(4 * i), 32'h80 | 32'(63 - 8 * i));
		apb(1'b1, ADDR_CHAN_LAST, 32'h0, 4'h0);
		rd(ADDR_CHAN_LAST, 32'h87, 1'b0);
		repeat (3 * CPER) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			check("channel high", 32'((63 - 8 * i) * STEP), hiW[i]);
			check("channel period", CPER, perW[i]);
		end
		wr(ADDR_CHAN_BASE + 12'h00c, 32'h3f);
		repeat (2 * CPER) @(posedge sys_clk);
		t0 = totW[3];
		repeat (CPER) @(posedge sys_clk);
		check("disabled channel", t0, totW[3]);
		wr(ADDR_TUNE_LOW, 32'h10);
		repeat (2 * TPER) @(posedge sys_clk);
		rd(ADDR_ACTIVE, 32'h0, 1'b0);
		check("tuning idle", 32'h0, totW[8]);
		wr(ADDR_TUNE_HIGH, 32'h85);
		repeat (2 * TPER) @(posedge sys_clk);
		rd(ADDR_ACTIVE, 32'h290, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0, 4'hf);
		check("status tuner enable", 32'h1, {31'h0, r[STAT_TUNE_EN_BIT]});
		check("status load pending", 32'h0, {31'h0, r[STAT_PENDING_BIT]});
		wr(ADDR_TUNE_LOW, 32'h00);
		t0 = totW[8];
		repeat (128 * TPER) @(posedge sys_clk);
		check("tuning charge", 32'(128 * 5 * STEP + 16 * STEP), totW[8] - t0);
		check("tuning period", TPER, perW[8]);
		rd(ADDR_ACTIVE, 32'h290, 1'b0);
		wr(ADDR_TUNE_HIGH, 32'hff);
		repeat (3 * TPER) @(posedge sys_clk);
		check("tuning high", 32'(127 * STEP), hiW[8]);
		wr(ADDR_TUNE_HIGH, 32'h7f);
		repeat (2 * TPER) @(posedge sys_clk);
		t0 = totW[8];
		repeat (TPER) @(posedge sys_clk);
		check("tuning disabled", t0, totW[8]);
		apb(1'b0, ADDR_STATUS, 32'h0, 4'hf);
		check("status tuner disabled", 32'h0, {31'h0, r[STAT_TUNE_EN_BIT]});
		check("status tuning low", 32'h0, {31'h0, r[STAT_TUNE_OUT_BIT]});
		final_report();
	end

	// Cuts a hang short.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			final_report();
		end
	end
endmodule
